//--- hdl/pdcs_dev_ctl_sts.sv
// Device control and device status configuration registers of one function.
// Assumes configuration cycles and function events arrive on clk as pulses.
//
// What this block does
// - Writing one to trigger bit starts function reset.
// - Trigger bit always reads back as zero.
// - Read request size field, resets to 010b.
// - No-snoop permit, resets one, gates attribute.
// - Wide tag enable, resets one, sets tag width unless ten-bit tag requests are enabled.
// - Payload size field, implementation reset value.
// - Relaxed-order permit, resets one, gates attribute.
// - Unsupported request reporting enable, resets zero.
// - Fatal reporting enable, resets zero.
// - Non-fatal reporting enable, resets zero.
// - Correctable reporting enable, resets zero.
// - Pending bit set while non-posted requests outstanding.
// - Pending clears after completions or timeouts.
// - Pending clears when function reset completes.
// - Unsupported request flag, sticky, write one clears.
// - Fatal error flag, sticky, write one clears.
// - Non-fatal error flag, sticky, write one clears.
// - Correctable error flag, sticky, write one clears.
`timescale 1ns/1ps
`default_nettype none
module pdcs_dev_ctl_sts (
   // Clock and reset.
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   // Configuration access.
   input  wire logic                            cfgWrEn,
   input  wire logic                            cfgRdEn,
   input  wire logic [pdcs_pkg::CFG_ADDR_W-1:0] cfgAddr,
   input  wire logic [1:0]                      cfgByteEn,
   input  wire logic [pdcs_pkg::REG_W-1:0]      cfgWrData,
   output logic      [pdcs_pkg::REG_W-1:0]      cfgRdData,
   output logic                                 cfgRdValid,
   // Function events.
   input  wire logic                            npReqIssued,
   input  wire logic                            npReqCompleted,
   input  wire logic                            npReqTimedOut,
   input  wire logic                            flrDone,
   input  wire logic                            errCorrectable,
   input  wire logic                            errNonfatal,
   input  wire logic                            errFatal,
   input  wire logic                            errUnsupportedReq,
   // Other controls.
   input  wire logic                            tenBitTagReqEnable,
   input  wire logic                            systemErrorEnable,
   // Controls to the function.
   output logic                                 flrStart,
   output logic      [2:0]                      readReqSizeLimit,
   output logic      [2:0]                      payloadSizeLimit,
   output logic                                 noSnoopPermit,
   output logic                                 relaxedOrderPermit,
   output logic      [3:0]                      tagWidth,
   // Error message requests.
   output logic                                 sendErrCor,
   output logic                                 sendErrNonfatal,
   output logic                                 sendErrFatal
);
   import pdcs_pkg::*;

   pdcs_flag_if flagBus ();

   logic                 pending;
   logic                 hitCtl;
   logic                 hitSts;
   logic                 wrCtlLo;
   logic                 wrCtlHi;
   logic                 wrStsLo;
   logic                 nonfatalGate;
   logic                 fatalGate;
   logic                 urReportable;

   logic                 flrStart_r;
   logic                 flrStart_nxt;
   logic [2:0]           readReqSizeLimit_r;
   logic [2:0]           readReqSizeLimit_nxt;
   logic                 noSnoopPermit_r;
   logic                 noSnoopPermit_nxt;
   logic                 wideTagEnable_r;
   logic                 wideTagEnable_nxt;
   logic [2:0]           payloadSizeLimit_r;
   logic [2:0]           payloadSizeLimit_nxt;
   logic                 relaxedOrderPermit_r;
   logic                 relaxedOrderPermit_nxt;
   logic [3:0]           reportEnable_r;
   logic [3:0]           reportEnable_nxt;

   logic [REG_W-1:0]     cfgRdData_r;
   logic [REG_W-1:0]     cfgRdData_nxt;
   logic                 cfgRdValid_r;
   logic                 cfgRdValid_nxt;
   logic [3:0]           tagWidth_r;
   logic [3:0]           tagWidth_nxt;
   logic                 sendErrCor_r;
   logic                 sendErrCor_nxt;
   logic                 sendErrNonfatal_r;
   logic                 sendErrNonfatal_nxt;
   logic                 sendErrFatal_r;
   logic                 sendErrFatal_nxt;
   logic [REG_W-1:0]     ctlView;
   logic [REG_W-1:0]     stsView;

   pdcs_err_flags uFlags (
      .clk   (clk),
      .rst_n (rst_n),
      .fl    (flagBus.owner)
   );

   pdcs_pending_tracker uPending (
      .clk          (clk),
      .rst_n        (rst_n),
      .reqIssued    (npReqIssued),
      .reqCompleted (npReqCompleted),
      .reqTimedOut  (npReqTimedOut),
      .flrDone      (flrDone),
      .pending      (pending)
   );

   // Address decode; byte lane 0 holds bits 7:0, lane 1 bits 15:8.
   // Offsets match in full, so a near miss reads zero and changes nothing.
   always_comb begin
      hitCtl  = (cfgAddr == DEV_CONTROL_OFF);
      hitSts  = (cfgAddr == DEV_STATUS_OFF);
      wrCtlLo = cfgWrEn & hitCtl & cfgByteEn[0];
      wrCtlHi = cfgWrEn & hitCtl & cfgByteEn[1];
      wrStsLo = cfgWrEn & hitSts & cfgByteEn[0];
   end

   // Error events and write-one-to-clear masks feed the sticky flags.
   // Only lane 0 can clear; the pending bit above the flags ignores writes.
   always_comb begin
      flagBus.evt[FLAG_COR]      = errCorrectable;
      flagBus.evt[FLAG_NONFATAL] = errNonfatal;
      flagBus.evt[FLAG_FATAL]    = errFatal;
      flagBus.evt[FLAG_UR]       = errUnsupportedReq;
      flagBus.clr = wrStsLo ? cfgWrData[NUM_FLAGS-1:0] : '0;
   end

   // Function reset trigger; the top bit is a one-cycle pulse and has no storage.
   always_comb begin
      flrStart_nxt = wrCtlHi & cfgWrData[FUNC_RESET_BIT];
   end

   // Control register next state; a completed function reset restores defaults
   // and outranks a write in the same cycle, so no stale field survives it.
   always_comb begin
      readReqSizeLimit_nxt   = readReqSizeLimit_r;
      noSnoopPermit_nxt      = noSnoopPermit_r;
      wideTagEnable_nxt      = wideTagEnable_r;
      payloadSizeLimit_nxt   = payloadSizeLimit_r;
      relaxedOrderPermit_nxt = relaxedOrderPermit_r;
      reportEnable_nxt       = reportEnable_r;
      if (flrDone) begin
         readReqSizeLimit_nxt   = RD_REQ_RST;
         noSnoopPermit_nxt      = DEV_CONTROL_RST[NO_SNOOP_BIT];
         wideTagEnable_nxt      = DEV_CONTROL_RST[WIDE_TAG_BIT];
         payloadSizeLimit_nxt   = PAYLOAD_RST;
         relaxedOrderPermit_nxt = DEV_CONTROL_RST[RELAXED_BIT];
         reportEnable_nxt       = DEV_CONTROL_RST[UR_REPORT_BIT:COR_REPORT_BIT];
      end else begin
         if (wrCtlHi) begin
            readReqSizeLimit_nxt = cfgWrData[RD_REQ_LSB +: 3];
            noSnoopPermit_nxt    = cfgWrData[NO_SNOOP_BIT];
            wideTagEnable_nxt    = cfgWrData[WIDE_TAG_BIT];
         end
         if (wrCtlLo) begin
            payloadSizeLimit_nxt   = cfgWrData[PAYLOAD_LSB +: 3];
            relaxedOrderPermit_nxt = cfgWrData[RELAXED_BIT];
            reportEnable_nxt       = cfgWrData[UR_REPORT_BIT:COR_REPORT_BIT];
         end
      end
   end

   // Control view; reserved bits and the trigger bit are held at zero.
   always_comb begin
      ctlView = '0;
      ctlView[FUNC_RESET_BIT] = 1'b0;
      ctlView[RD_REQ_LSB +: 3] = readReqSizeLimit_r;
      ctlView[NO_SNOOP_BIT] = noSnoopPermit_r;
      ctlView[WIDE_TAG_BIT] = wideTagEnable_r;
      ctlView[PAYLOAD_LSB +: 3] = payloadSizeLimit_r;
      ctlView[RELAXED_BIT] = relaxedOrderPermit_r;
      ctlView[UR_REPORT_BIT:COR_REPORT_BIT] = reportEnable_r;
   end

   // Status view; only the pending bit and the four flags are backed by state.
   always_comb begin
      stsView = '0;
      stsView[PENDING_BIT] = pending;
      stsView[NUM_FLAGS-1:0] = flagBus.flags;
   end

   // Read answer one cycle after the request; unmapped offsets read zero.
   // A write in the same cycle lands after the read, so the read sees old values.
   always_comb begin
      cfgRdValid_nxt = cfgRdEn;
      cfgRdData_nxt  = '0;
      if (cfgRdEn && hitCtl) begin
         cfgRdData_nxt = ctlView;
      end else if (cfgRdEn && hitSts) begin
         cfgRdData_nxt = stsView;
      end
   end

   // Tag width seen by the requester logic; lags its inputs by one cycle.
   always_comb begin
      if (tenBitTagReqEnable) begin
         tagWidth_nxt = TAG_W_TEN;
      end else if (wideTagEnable_r) begin
         tagWidth_nxt = TAG_W_EIGHT;
      end else begin
         tagWidth_nxt = TAG_W_FIVE;
      end
   end

   // Error message requests; an unsupported request goes out as non-fatal.
   always_comb begin
      nonfatalGate        = reportEnable_r[NONFATAL_REP_BIT] | systemErrorEnable;
      fatalGate           = reportEnable_r[FATAL_REPORT_BIT] | systemErrorEnable;
      urReportable        = errUnsupportedReq & reportEnable_r[UR_REPORT_BIT];
      sendErrCor_nxt      = errCorrectable & reportEnable_r[COR_REPORT_BIT];
      sendErrNonfatal_nxt = (errNonfatal | urReportable) & nonfatalGate;
      sendErrFatal_nxt    = errFatal & fatalGate;
   end

   // Function reset trigger register.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flrStart_r <= 1'b0;
      end else begin
         flrStart_r <= flrStart_nxt;
      end
   end

   // Control field registers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readReqSizeLimit_r   <= RD_REQ_RST;
         noSnoopPermit_r      <= DEV_CONTROL_RST[NO_SNOOP_BIT];
         wideTagEnable_r      <= DEV_CONTROL_RST[WIDE_TAG_BIT];
         payloadSizeLimit_r   <= PAYLOAD_RST;
         relaxedOrderPermit_r <= DEV_CONTROL_RST[RELAXED_BIT];
         reportEnable_r       <= DEV_CONTROL_RST[UR_REPORT_BIT:COR_REPORT_BIT];
      end else begin
         readReqSizeLimit_r   <= readReqSizeLimit_nxt;
         noSnoopPermit_r      <= noSnoopPermit_nxt;
         wideTagEnable_r      <= wideTagEnable_nxt;
         payloadSizeLimit_r   <= payloadSizeLimit_nxt;
         relaxedOrderPermit_r <= relaxedOrderPermit_nxt;
         reportEnable_r       <= reportEnable_nxt;
      end
   end

   // Read answer registers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfgRdData_r  <= '0;
         cfgRdValid_r <= 1'b0;
      end else begin
         cfgRdData_r  <= cfgRdData_nxt;
         cfgRdValid_r <= cfgRdValid_nxt;
      end
   end

   // Tag width register.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tagWidth_r <= TAG_W_EIGHT;
      end else begin
         tagWidth_r <= tagWidth_nxt;
      end
   end

   // Error message request registers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sendErrCor_r      <= 1'b0;
         sendErrNonfatal_r <= 1'b0;
         sendErrFatal_r    <= 1'b0;
      end else begin
         sendErrCor_r      <= sendErrCor_nxt;
         sendErrNonfatal_r <= sendErrNonfatal_nxt;
         sendErrFatal_r    <= sendErrFatal_nxt;
      end
   end

   assign flrStart           = flrStart_r;
   assign readReqSizeLimit   = readReqSizeLimit_r;
   assign payloadSizeLimit   = payloadSizeLimit_r;
   assign noSnoopPermit      = noSnoopPermit_r;
   assign relaxedOrderPermit = relaxedOrderPermit_r;
   assign tagWidth           = tagWidth_r;
   assign cfgRdData          = cfgRdData_r;
   assign cfgRdValid         = cfgRdValid_r;
   assign sendErrCor         = sendErrCor_r;
   assign sendErrNonfatal    = sendErrNonfatal_r;
   assign sendErrFatal       = sendErrFatal_r;
endmodule : pdcs_dev_ctl_sts
`default_nettype wire

//--- hdl/pdcs_pkg.sv
// Constants shared by the device control and status register pair.
// Assumes a single 20 MHz clock and 12-bit configuration byte addresses.
package pdcs_pkg;
   localparam int          CFG_ADDR_W       = 12;
   localparam int          REG_W            = 16;
   localparam int          NUM_FLAGS        = 4;
   localparam int          PENDING_CNT_W    = 8;

   localparam logic [11:0] DEV_CONTROL_OFF  = 12'h048;
   localparam logic [11:0] DEV_STATUS_OFF   = 12'h04a;

   localparam logic [15:0] DEV_CONTROL_RST  = 16'h2910;
   localparam logic [15:0] DEV_STATUS_RST   = 16'h0000;

   // Control field positions.
   localparam int          FUNC_RESET_BIT   = 15;
   localparam int          RD_REQ_LSB       = 12;
   localparam int          NO_SNOOP_BIT     = 11;
   localparam int          WIDE_TAG_BIT     = 8;
   localparam int          PAYLOAD_LSB      = 5;
   localparam int          RELAXED_BIT      = 4;
   localparam int          UR_REPORT_BIT    = 3;
   localparam int          FATAL_REPORT_BIT = 2;
   localparam int          NONFATAL_REP_BIT = 1;
   localparam int          COR_REPORT_BIT   = 0;

   // Status field positions; flag index equals bit position.
   localparam int          PENDING_BIT      = 5;
   localparam int          FLAG_COR         = 0;
   localparam int          FLAG_NONFATAL    = 1;
   localparam int          FLAG_FATAL       = 2;
   localparam int          FLAG_UR          = 3;

   // Payload size after reset; the value is the implementation's own pick.
   localparam logic [2:0]  PAYLOAD_RST      = 3'h0;
   localparam logic [2:0]  RD_REQ_RST       = 3'h2;

   localparam logic [3:0]  TAG_W_TEN        = 4'ha;
   localparam logic [3:0]  TAG_W_EIGHT      = 4'h8;
   localparam logic [3:0]  TAG_W_FIVE       = 4'h5;
endpackage : pdcs_pkg

//--- hdl/pdcs_flag_if.sv
// Carries error events, write-one-to-clear masks and the sticky flags.
// Assumes the owner and the user share one clock.
`timescale 1ns/1ps
`default_nettype none
interface pdcs_flag_if;
   import pdcs_pkg::*;
   logic [NUM_FLAGS-1:0] evt;
   logic [NUM_FLAGS-1:0] clr;
   logic [NUM_FLAGS-1:0] flags;
   modport owner (input evt, input clr, output flags);
   modport user  (output evt, output clr, input flags);
endinterface : pdcs_flag_if
`default_nettype wire

//--- hdl/pdcs_err_flags.sv
// Sticky error flags of the device status register, one per error class.
// Assumes events and clears are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pdcs_err_flags (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Events, clears and flags.
   pdcs_flag_if.owner fl
);
   import pdcs_pkg::*;

   logic [NUM_FLAGS-1:0] flags_r;
   logic [NUM_FLAGS-1:0] flags_nxt;

   genvar i;
   generate
      for (i = 0; i < NUM_FLAGS; i++) begin : gFlag
         // A set in the same cycle as a clear wins, so no event is lost.
         always_comb begin
            flags_nxt[i] = fl.evt[i] | (flags_r[i] & ~fl.clr[i]);
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_r <= DEV_STATUS_RST[NUM_FLAGS-1:0];
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign fl.flags = flags_r;
endmodule : pdcs_err_flags
`default_nettype wire

//--- hdl/pdcs_pending_tracker.sv
// Counts non-posted requests that still await completion.
// Assumes issue, completion and timeout are one-cycle pulses from the requester.
`timescale 1ns/1ps
`default_nettype none
module pdcs_pending_tracker
   import pdcs_pkg::*;
(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Request tracking.
   input  wire logic reqIssued,
   input  wire logic reqCompleted,
   input  wire logic reqTimedOut,
   input  wire logic flrDone,
   // State.
   output logic      pending
);
   logic [PENDING_CNT_W-1:0] count_r;
   logic [PENDING_CNT_W-1:0] count_nxt;
   logic                     retire;

   always_comb begin
      retire    = reqCompleted | reqTimedOut;
      count_nxt = count_r;
      if (flrDone) begin
         count_nxt = '0;
      end else if (reqIssued && !retire && count_r != '1) begin
         count_nxt = count_r + PENDING_CNT_W'(1);
      end else if (!reqIssued && retire && count_r != '0) begin
         count_nxt = count_r - PENDING_CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   assign pending = (count_r != '0);
endmodule : pdcs_pending_tracker
`default_nettype wire

//--- verification/pdcs_dev_ctl_sts_properties.sv
// Port-level checker for the device control and status register pair.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pdcs_dev_ctl_sts_properties import pdcs_pkg::*; (
   // Clock and reset.
   input wire logic                  clk,
   input wire logic                  rst_n,
   // Configuration access.
   input wire logic                  cfgWrEn,
   input wire logic                  cfgRdEn,
   input wire logic [CFG_ADDR_W-1:0] cfgAddr,
   input wire logic [1:0]            cfgByteEn,
   input wire logic [REG_W-1:0]      cfgWrData,
   input wire logic [REG_W-1:0]      cfgRdData,
   input wire logic                  cfgRdValid,
   // Function events.
   input wire logic                  npReqIssued,
   input wire logic                  npReqCompleted,
   input wire logic                  npReqTimedOut,
   input wire logic                  flrDone,
   input wire logic                  errCorrectable,
   input wire logic                  errNonfatal,
   input wire logic                  errFatal,
   input wire logic                  errUnsupportedReq,
   // Other controls.
   input wire logic                  tenBitTagReqEnable,
   input wire logic                  systemErrorEnable,
   // Controls and messages.
   input wire logic                  flrStart,
   input wire logic [2:0]            readReqSizeLimit,
   input wire logic [2:0]            payloadSizeLimit,
   input wire logic                  noSnoopPermit,
   input wire logic                  relaxedOrderPermit,
   input wire logic [3:0]            tagWidth,
   input wire logic                  sendErrCor,
   input wire logic                  sendErrNonfatal,
   input wire logic                  sendErrFatal
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   read_answer_a: assert property (cfgRdEn |=> cfgRdValid && cfgRdData[15] == 1'b0)
      else $error("read not answered with trigger bit clear");
   read_idle_a: assert property (!cfgRdValid |-> cfgRdData == 16'h0000)
      else $error("read data not zero while idle");
   reserved_zero_a: assert property (cfgRdValid && $past(cfgAddr) == DEV_STATUS_OFF
      |-> cfgRdData[15:6] == 10'h000 && !cfgRdData[4])
      else $error("status reserved bits not zero");
   flr_start_a: assert property (cfgWrEn && cfgAddr == DEV_CONTROL_OFF && cfgByteEn[1]
      && cfgWrData[15] |=> flrStart ##1 !flrStart)
      else $error("function reset trigger not pulsed");
   flr_cause_a: assert property (flrStart |-> $past(cfgWrEn && cfgAddr == DEV_CONTROL_OFF
      && cfgByteEn[1] && cfgWrData[15]))
      else $error("function reset started without a write");
   fatal_msg_a: assert property (errFatal && systemErrorEnable |=> sendErrFatal)
      else $error("fatal message missing");
   cor_msg_a: assert property (sendErrCor |-> $past(errCorrectable))
      else $error("correctable message without event");
   nonfatal_msg_a: assert property (sendErrNonfatal
      |-> $past(errNonfatal || errUnsupportedReq))
      else $error("nonfatal message without event");
   tag_ten_a: assert property (tenBitTagReqEnable |=> tagWidth == TAG_W_TEN)
      else $error("tag width not ten");
   flr_default_a: assert property (flrDone
      |=> readReqSizeLimit == RD_REQ_RST && noSnoopPermit && relaxedOrderPermit
      && payloadSizeLimit == PAYLOAD_RST)
      else $error("controls not restored after function reset");
   size_hold_a: assert property (!cfgWrEn && !flrDone |=> $stable(readReqSizeLimit))
      else $error("read request size changed without a write");

   cover property (cfgRdEn ##1 cfgRdValid);
   cover property (flrStart);
   cover property (sendErrFatal);
   cover property (sendErrNonfatal);
endmodule : pdcs_dev_ctl_sts_properties

bind pdcs_dev_ctl_sts pdcs_dev_ctl_sts_properties chk_u (
   .clk(clk), .rst_n(rst_n), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
   .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
   .cfgRdValid(cfgRdValid), .npReqIssued(npReqIssued), .npReqCompleted(npReqCompleted),
   .npReqTimedOut(npReqTimedOut), .flrDone(flrDone), .errCorrectable(errCorrectable),
   .errNonfatal(errNonfatal), .errFatal(errFatal), .errUnsupportedReq(errUnsupportedReq),
   .tenBitTagReqEnable(tenBitTagReqEnable), .systemErrorEnable(systemErrorEnable),
   .flrStart(flrStart), .readReqSizeLimit(readReqSizeLimit),
   .payloadSizeLimit(payloadSizeLimit), .noSnoopPermit(noSnoopPermit),
   .relaxedOrderPermit(relaxedOrderPermit), .tagWidth(tagWidth), .sendErrCor(sendErrCor),
   .sendErrNonfatal(sendErrNonfatal), .sendErrFatal(sendErrFatal));
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the device control and status register pair.
// Assumes the bound checker file is compiled alongside the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pdcs_pkg::*;
   localparam logic [15:0] CTL_WR_MASK = 16'h79ff;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cfgWrEn = 1'b0;
   logic        cfgRdEn = 1'b0;
   logic [11:0] cfgAddr = 12'h000;
   logic [1:0]  cfgByteEn = 2'h0;
   logic [15:0] cfgWrData = 16'h0000;
   logic [3:0]  err = 4'h0;
   logic [3:0]  np = 4'h0;
   logic        tenBit = 1'b0;
   logic        sysErr = 1'b0;
   logic [15:0] cfgRdData;
   logic        cfgRdValid, flrStart, noSnoop, relaxed, sCor, sNonfatal, sFatal;
   logic [2:0]  rdSize, paySize;
   logic [3:0]  tagWidth;
   logic [15:0] expCtl = DEV_CONTROL_RST;
   logic [3:0]  expFlags = 4'h0;
   logic [11:0] a;
   int          pendCnt = 0, fail_count = 0, checks_done = 0, cycles = 0, n, rnd;

   pdcs_dev_ctl_sts dut_u (.clk(clk), .rst_n(rst_n), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
      .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .npReqIssued(np[0]), .npReqCompleted(np[1]),
      .npReqTimedOut(np[2]), .flrDone(np[3]), .errCorrectable(err[0]), .errNonfatal(err[1]),
      .errFatal(err[2]), .errUnsupportedReq(err[3]), .tenBitTagReqEnable(tenBit),
      .systemErrorEnable(sysErr), .flrStart(flrStart), .readReqSizeLimit(rdSize),
      .payloadSizeLimit(paySize), .noSnoopPermit(noSnoop), .relaxedOrderPermit(relaxed),
      .tagWidth(tagWidth), .sendErrCor(sCor), .sendErrNonfatal(sNonfatal), .sendErrFatal(sFatal));

   always #25 clk = ~clk;

   // Cuts a hung run short well past the expected length.
   always @(posedge clk) begin
      cycles++;
      if (cycles > 5000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   task automatic sync();
      @(posedge clk);
      #2;
   endtask : sync

   function automatic logic [15:0] exp_sts();
      return {10'h000, pendCnt != 0, 1'b0, expFlags};
   endfunction : exp_sts

   task automatic wr(input logic [11:0] ad, input logic [1:0] be, input logic [15:0] d);
      logic [15:0] m;
      sync();
      cfgWrEn = 1'b1;
      cfgAddr = ad;
      cfgByteEn = be;
      cfgWrData = d;
      sync();
      cfgWrEn = 1'b0;
      m = {{8{be[1]}}, {8{be[0]}}} & CTL_WR_MASK;
      if (ad == DEV_CONTROL_OFF) expCtl = (expCtl & ~m) | (d & m);
      if (ad == DEV_STATUS_OFF && be[0]) expFlags = expFlags & ~d[3:0];
      chk({15'h0, flrStart}, {15'h0, ad == DEV_CONTROL_OFF && be[1] && d[15]});
   endtask : wr

   task automatic rd(input logic [11:0] ad, input logic [15:0] exp);
      sync();
      cfgRdEn = 1'b1;
      cfgAddr = ad;
      sync();
      cfgRdEn = 1'b0;
      chk({15'h0, cfgRdValid}, 16'h0001);
      chk(cfgRdData, exp);
   endtask : rd

   task automatic fields();
      chk({1'b0, rdSize, noSnoop, 3'h0, paySize, relaxed, 4'h0},
          expCtl & 16'h78f0);
   endtask : fields

   // Pulses one error class, optionally with a clearing write in the same cycle.
   task automatic evt(input int i, input logic clrToo);
      logic [2:0] e;
      logic [3:0] c;
      c = expCtl[3:0];
      sync();
      err[i] = 1'b1;
      cfgWrEn = clrToo;
      cfgAddr = DEV_STATUS_OFF;
      cfgByteEn = 2'h1;
      cfgWrData = 16'h000f;
      sync();
      err = 4'h0;
      cfgWrEn = 1'b0;
      if (clrToo) expFlags = 4'h0;
      expFlags[i] = 1'b1;
      e = {i == 2 && (c[2] || sysErr), (i == 1 || (i == 3 && c[3])) && (c[1] || sysErr),
           i == 0 && c[0]};
      chk({13'h0, sFatal, sNonfatal, sCor}, {13'h0, e});
   endtask : evt

   // Index 0 issues, 1 completes, 2 times out, 3 finishes a function reset.
   task automatic np_pulse(input int k);
      sync();
      np[k] = 1'b1;
      sync();
      np = 4'h0;
      if (k == 0) pendCnt++;
      else if (k == 3) pendCnt = 0;
      else if (pendCnt > 0) pendCnt--;
      if (k == 3) expCtl = DEV_CONTROL_RST;
   endtask : np_pulse

   initial begin
      rnd = $urandom(90);
      repeat (3) @(posedge clk);
      #2 rst_n = 1'b1;
      rd(DEV_CONTROL_OFF, DEV_CONTROL_RST);
      rd(DEV_STATUS_OFF, DEV_STATUS_RST);
      fields();
      chk({12'h0, tagWidth}, {12'h0, TAG_W_EIGHT});
      wr(DEV_CONTROL_OFF, 2'h3, 16'hffff);
      rd(DEV_CONTROL_OFF, expCtl);
      wr(12'h04c, 2'h3, 16'h0000);
      rd(12'h04c, 16'h0000);
      repeat (24) begin
         a = 12'($urandom);
         if ($urandom_range(2) == 0) a = DEV_CONTROL_OFF;
         wr(a, 2'($urandom_range(3)), 16'($urandom));
         rd(DEV_CONTROL_OFF, expCtl);
         fields();
      end
      for (int t = 0; t < 4; t++) begin
         wr(DEV_CONTROL_OFF, 2'h2, 16'(t[0]) << WIDE_TAG_BIT);
         tenBit = t[1];
         sync();
         chk({12'h0, tagWidth},
             {12'h0, t[1] ? TAG_W_TEN : (t[0] ? TAG_W_EIGHT : TAG_W_FIVE)});
      end
      for (int k = 0; k < 16; k++) begin
         sysErr = 1'($urandom);
         wr(DEV_CONTROL_OFF, 2'h1, 16'($urandom_range(15)));
         evt(k % 4, k >= 12);
         rd(DEV_STATUS_OFF, exp_sts());
         wr(DEV_STATUS_OFF, 2'($urandom_range(3)), 16'($urandom));
         rd(DEV_STATUS_OFF, exp_sts());
      end
      n = $urandom_range(5, 1);
      repeat (n) np_pulse(0);
      rd(DEV_STATUS_OFF, exp_sts());
      repeat (n - 1) np_pulse(1);
      rd(DEV_STATUS_OFF, exp_sts());
      np_pulse(2);
      rd(DEV_STATUS_OFF, exp_sts());
      np_pulse(0);
      wr(DEV_CONTROL_OFF, 2'h3, 16'h0000);
      np_pulse(3);
      rd(DEV_STATUS_OFF, exp_sts());
      rd(DEV_CONTROL_OFF, expCtl);
      fields();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
